// *** ptl_pkg.sv ***
// constants, register map and types shared by the positioning terminal logic
`default_nettype none
package ptl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	// one millisecond in clock cycles
	localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 17;
	localparam int END_WAIT_MIN_MS = 500;
	localparam int HOLD_MS = 100;
	localparam int MS_W = 16;
	localparam int HOLD_W = 8;
	localparam int POS_W = 26;
	localparam int ADDR_W = 8;
	localparam logic signed [POS_W-1:0] POS_LIMIT = 26'sh098967F;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] REG_START_DELAY = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_END_WAIT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_WINDOW = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PRESET = 8'h18;
	localparam logic [ADDR_W-1:0] REG_TARGET = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_START_POINT = 8'h20;
	localparam logic [ADDR_W-1:0] REG_POSITION = 8'h24;
	localparam logic [ADDR_W-1:0] REG_STATE = 8'h28;
	localparam int CTRL_EXCL_BIT = 0;
	localparam int ST_DONE_BIT = 0;
	localparam int ST_ALARM_BIT = 1;
	localparam int ST_OVF_BIT = 2;
	localparam int ST_PRESET_BIT = 3;
	localparam int ST_W = 4;
	localparam logic [MS_W-1:0] START_DELAY_RST = 16'h0000;
	localparam logic [MS_W-1:0] END_WAIT_RST = 16'h01F4;
	localparam logic [POS_W-1:0] WINDOW_RST = 26'h0000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		stIdle,
		stWaitRun,
		stStartDelay,
		stRunning,
		stEndWait,
		stResult
	} ptl_state_e;
endpackage : ptl_pkg
`default_nettype wire

// *** ptl_min_hold.sv ***
// stretches a status level so it stays on for a minimum number of milliseconds
`default_nettype none
module ptl_min_hold (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic msTick,
	input  wire logic trigger,
	output logic      holdOut
);
	typedef struct packed {
		logic [ptl_pkg::HOLD_W-1:0] cnt;
		logic                       out;
	} ptl_hold_s;

	ptl_hold_s hold_r;
	ptl_hold_s hold_nxt;

	always_comb
	begin
		hold_nxt = hold_r;
		if (trigger)
			hold_nxt.cnt = ptl_pkg::HOLD_W'(ptl_pkg::HOLD_MS);
		else if (msTick && hold_r.cnt != '0)
			hold_nxt.cnt = hold_r.cnt - 1'b1;
		hold_nxt.out = trigger | (hold_r.cnt != '0);
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			hold_r <= '0;
		else
			hold_r <= hold_nxt;
	end

	assign holdOut = hold_r.out;
endmodule : ptl_min_hold
`default_nettype wire

// *** ptl_axil_slave.sv ***
// axi4-lite slave front end: one write and one read in flight
`default_nettype none
module ptl_axil_slave (
	input  wire logic                        ref_clk,
	input  wire logic                        reset_n,
	input  wire logic [ptl_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ptl_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic                             wrEn,
	output logic [ptl_pkg::ADDR_W-1:0]       wrAddr,
	output logic [31:0]                      wrData,
	output logic [3:0]                       wrStrb,
	input  wire logic                        wrErr,
	output logic                             rdEn,
	output logic [ptl_pkg::ADDR_W-1:0]       rdAddr,
	input  wire logic [31:0]                 rdData,
	input  wire logic                        rdErr
);
	typedef struct packed {
		logic                       awHeld;
		logic                       wHeld;
		logic [ptl_pkg::ADDR_W-1:0] awAddr;
		logic [31:0]                wData;
		logic [3:0]                 wStrb;
		logic                       bValid;
		logic [1:0]                 bResp;
		logic                       rValid;
		logic [1:0]                 rResp;
		logic [31:0]                rData;
	} ptl_axil_s;

	ptl_axil_s bus_r;
	ptl_axil_s bus_nxt;

	assign s_axi_awready = !bus_r.awHeld;
	assign s_axi_wready = !bus_r.wHeld;
	assign s_axi_arready = !bus_r.rValid;
	// fire only once the previous response has drained
	assign wrEn = bus_r.awHeld & bus_r.wHeld & !bus_r.bValid;
	assign wrAddr = bus_r.awAddr;
	assign wrData = bus_r.wData;
	assign wrStrb = bus_r.wStrb;
	assign rdEn = s_axi_arvalid & !bus_r.rValid;
	assign rdAddr = s_axi_araddr;

	always_comb
	begin
		bus_nxt = bus_r;
		if (s_axi_awvalid && !bus_r.awHeld)
		begin
			bus_nxt.awHeld = 1'b1;
			bus_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !bus_r.wHeld)
		begin
			bus_nxt.wHeld = 1'b1;
			bus_nxt.wData = s_axi_wdata;
			bus_nxt.wStrb = s_axi_wstrb;
		end
		if (bus_r.bValid && s_axi_bready)
			bus_nxt.bValid = 1'b0;
		if (wrEn)
		begin
			bus_nxt.awHeld = 1'b0;
			bus_nxt.wHeld = 1'b0;
			bus_nxt.bValid = 1'b1;
			bus_nxt.bResp = wrErr ? ptl_pkg::RESP_SLVERR : ptl_pkg::RESP_OKAY;
		end
		if (bus_r.rValid && s_axi_rready)
			bus_nxt.rValid = 1'b0;
		if (rdEn)
		begin
			bus_nxt.rValid = 1'b1;
			bus_nxt.rData = rdErr ? 32'h00000000 : rdData;
			bus_nxt.rResp = rdErr ? ptl_pkg::RESP_SLVERR : ptl_pkg::RESP_OKAY;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			bus_r <= '0;
		else
			bus_r <= bus_nxt;
	end

	assign s_axi_bvalid = bus_r.bValid;
	assign s_axi_bresp = bus_r.bResp;
	assign s_axi_rvalid = bus_r.rValid;
	assign s_axi_rresp = bus_r.rResp;
	assign s_axi_rdata = bus_r.rData;
endmodule : ptl_axil_slave
`default_nettype wire

// *** ptl_terminal.sv ***
// positioning terminal logic: position count, stop sequence and status outputs
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`default_nettype none
module ptl_terminal #(
	parameter int TICK_CYCLES = ptl_pkg::TICK_CYCLES
) (
	input  wire logic                        ref_clk,
	input  wire logic                        reset_n,
	input  wire logic                        positionEnable,
	input  wire logic                        limitSwitchArm,
	input  wire logic                        encoderIndex,
	input  wire logic                        encoderPulseInput,
	input  wire logic                        encoderReverse,
	input  wire logic                        serialPulse,
	input  wire logic                        serialCountMode,
	input  wire logic                        returnModeSelect,
	input  wire logic                        runCommand,
	input  wire logic                        motorStopped,
	output logic                             stopOverrunAlarm,
	output logic                             timerActiveOut,
	output logic                             positionDone,
	output logic                             positionCountOverflow,
	output logic                             driveRun,
	output logic                             moveReverse,
	output logic [ptl_pkg::POS_W-1:0]        moveTarget,
	output logic                             irq,
	input  wire logic [ptl_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ptl_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	typedef struct packed {
		ptl_pkg::ptl_state_e                st;
		logic [ptl_pkg::TICK_W-1:0]         tick;
		logic                               msTick;
		logic [ptl_pkg::MS_W-1:0]           msCnt;
		logic                               armed;
		logic                               limPrev;
		logic                               idxPrev;
		logic                               encPrev;
		logic                               serPrev;
		logic                               modePrev;
		logic                               runPrev;
		logic                               outPrev;
		logic                               ovf;
		logic signed [ptl_pkg::POS_W-1:0]   pos;
		logic [ptl_pkg::POS_W-1:0]          target;
		logic [ptl_pkg::POS_W-1:0]          startPt;
		logic [ptl_pkg::POS_W-1:0]          preset;
		logic [ptl_pkg::POS_W-1:0]          window;
		logic [ptl_pkg::MS_W-1:0]           startDelay;
		logic [ptl_pkg::MS_W-1:0]           endWait;
		logic                               exclusive;
		logic [ptl_pkg::ST_W-1:0]           status;
		logic [ptl_pkg::ST_W-1:0]           mask;
		logic                               reverse;
		logic [ptl_pkg::POS_W-1:0]          moveTgt;
		logic                               done;
		logic                               alarm;
	} ptl_term_s;

	ptl_term_s t_r;
	ptl_term_s t_nxt;

	logic                       wrEn;
	logic [ptl_pkg::ADDR_W-1:0] wrAddr;
	logic [31:0]                wrData;
	logic [3:0]                 wrStrb;
	logic                       wrErr;
	logic                       rdEn;
	logic [ptl_pkg::ADDR_W-1:0] rdAddr;
	logic [31:0]                rdData;
	logic                       rdErr;

	ptl_axil_slave u_bus (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wrEn          (wrEn),
		.wrAddr        (wrAddr),
		.wrData        (wrData),
		.wrStrb        (wrStrb),
		.wrErr         (wrErr),
		.rdEn          (rdEn),
		.rdAddr        (rdAddr),
		.rdData        (rdData),
		.rdErr         (rdErr)
	);

	ptl_min_hold u_holdDone (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.msTick  (t_r.msTick),
		.trigger (t_r.done),
		.holdOut (positionDone)
	);

	ptl_min_hold u_holdAlarm (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.msTick  (t_r.msTick),
		.trigger (t_r.alarm),
		.holdOut (stopOverrunAlarm)
	);

	function automatic logic [31:0] ptl_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[8*i +: 8] = nw[8*i +: 8];
		return res;
	endfunction : ptl_merge

	logic                              wrHit;
	logic                              rdHit;
	logic                              outNow;
	logic signed [ptl_pkg::POS_W-1:0]  dev;
	logic [ptl_pkg::POS_W-1:0]         absDev;
	logic [ptl_pkg::MS_W-1:0]          endLimit;
	logic                              runRise;
	logic                              idxRise;
	logic [ptl_pkg::ST_W-1:0]          events;

	always_comb
	begin
		unique case (wrAddr)
			ptl_pkg::REG_CTRL, ptl_pkg::REG_STATUS, ptl_pkg::REG_MASK, ptl_pkg::REG_START_DELAY,
			ptl_pkg::REG_END_WAIT, ptl_pkg::REG_WINDOW, ptl_pkg::REG_PRESET, ptl_pkg::REG_TARGET,
			ptl_pkg::REG_START_POINT: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
		rdHit = 1'b1;
		rdData = 32'h00000000;
		unique case (rdAddr)
			ptl_pkg::REG_CTRL: rdData[ptl_pkg::CTRL_EXCL_BIT] = t_r.exclusive;
			ptl_pkg::REG_STATUS: rdData[ptl_pkg::ST_W-1:0] = t_r.status;
			ptl_pkg::REG_MASK: rdData[ptl_pkg::ST_W-1:0] = t_r.mask;
			ptl_pkg::REG_START_DELAY: rdData[ptl_pkg::MS_W-1:0] = t_r.startDelay;
			ptl_pkg::REG_END_WAIT: rdData[ptl_pkg::MS_W-1:0] = t_r.endWait;
			ptl_pkg::REG_WINDOW: rdData[ptl_pkg::POS_W-1:0] = t_r.window;
			ptl_pkg::REG_PRESET: rdData = 32'(signed'(t_r.preset));
			ptl_pkg::REG_TARGET: rdData = 32'(signed'(t_r.target));
			ptl_pkg::REG_START_POINT: rdData = 32'(signed'(t_r.startPt));
			ptl_pkg::REG_POSITION: rdData = 32'(t_r.pos);
			ptl_pkg::REG_STATE: rdData[6:0] = {t_r.ovf, t_r.armed, t_r.reverse, 1'b0, t_r.st};
			default: rdHit = 1'b0;
		endcase
	end

	assign wrErr = !wrHit;
	assign rdErr = !rdHit;

	always_comb
	begin
		t_nxt = t_r;
		events = '0;
		runRise = runCommand & !t_r.runPrev;
		idxRise = encoderIndex & !t_r.idxPrev;
		dev = t_r.pos - signed'(t_r.target);
		absDev = dev[ptl_pkg::POS_W-1] ? ptl_pkg::POS_W'(-dev) : ptl_pkg::POS_W'(dev);
		// the end wait is never shorter than the floor
		endLimit = (t_r.endWait < ptl_pkg::MS_W'(ptl_pkg::END_WAIT_MIN_MS)) ?
			ptl_pkg::MS_W'(ptl_pkg::END_WAIT_MIN_MS) : t_r.endWait;
		t_nxt.limPrev = limitSwitchArm;
		t_nxt.idxPrev = encoderIndex;
		t_nxt.encPrev = encoderPulseInput;
		t_nxt.serPrev = serialPulse;
		t_nxt.modePrev = serialCountMode;
		t_nxt.runPrev = runCommand;
		t_nxt.msTick = 1'b0;
		if (t_r.tick == ptl_pkg::TICK_W'(TICK_CYCLES - 1))
		begin
			t_nxt.tick = '0;
			t_nxt.msTick = 1'b1;
		end
		else
			t_nxt.tick = t_r.tick + 1'b1;

		if (encoderPulseInput && !t_r.encPrev)
			t_nxt.pos = encoderReverse ? t_r.pos - 1'b1 : t_r.pos + 1'b1;
		// arm only, then preset on index
		if (limitSwitchArm && !t_r.limPrev)
			t_nxt.armed = 1'b1;
		if (t_r.armed && idxRise)
		begin
			t_nxt.armed = 1'b0;
			t_nxt.pos = signed'(t_r.preset);
			events[ptl_pkg::ST_PRESET_BIT] = 1'b1;
		end

		// overflow set on leaving, clear on return
		outNow = (t_r.pos > ptl_pkg::POS_LIMIT) || (t_r.pos < -ptl_pkg::POS_LIMIT);
		t_nxt.outPrev = outNow;
		if (!outNow)
			t_nxt.ovf = 1'b0;
		else if (!t_r.outPrev)
		begin
			t_nxt.ovf = 1'b1;
			events[ptl_pkg::ST_OVF_BIT] = 1'b1;
		end
		if (runRise && positionEnable)
			t_nxt.ovf = 1'b0;
		if (t_r.armed && idxRise)
			t_nxt.ovf = 1'b0;

		if (wrEn)
		begin
			unique case (wrAddr)
				ptl_pkg::REG_CTRL:
					t_nxt.exclusive = 1'(ptl_merge(32'(t_r.exclusive), wrData, wrStrb) >> ptl_pkg::CTRL_EXCL_BIT);
				ptl_pkg::REG_MASK: t_nxt.mask = ptl_pkg::ST_W'(ptl_merge(32'(t_r.mask), wrData, wrStrb));
				ptl_pkg::REG_START_DELAY:
					t_nxt.startDelay = ptl_pkg::MS_W'(ptl_merge(32'(t_r.startDelay), wrData, wrStrb));
				ptl_pkg::REG_END_WAIT:
					t_nxt.endWait = ptl_pkg::MS_W'(ptl_merge(32'(t_r.endWait), wrData, wrStrb));
				ptl_pkg::REG_WINDOW:
					t_nxt.window = ptl_pkg::POS_W'(ptl_merge(32'(t_r.window), wrData, wrStrb));
				ptl_pkg::REG_PRESET:
					t_nxt.preset = ptl_pkg::POS_W'(ptl_merge(32'(t_r.preset), wrData, wrStrb));
				ptl_pkg::REG_TARGET:
					t_nxt.target = ptl_pkg::POS_W'(ptl_merge(32'(t_r.target), wrData, wrStrb));
				ptl_pkg::REG_START_POINT:
					t_nxt.startPt = ptl_pkg::POS_W'(ptl_merge(32'(t_r.startPt), wrData, wrStrb));
				default: ;
			endcase
		end
		if (serialPulse && !t_r.serPrev && (t_r.exclusive || serialCountMode))
			t_nxt.target = t_r.target + 1'b1;
		// mode edge clears target, beats everything
		if (serialCountMode && !t_r.modePrev)
			t_nxt.target = '0;

		t_nxt.done = 1'b0;
		t_nxt.alarm = 1'b0;
		if (t_r.msTick)
			t_nxt.msCnt = t_r.msCnt + 1'b1;
		unique case (t_r.st)
			ptl_pkg::stIdle:
				if (positionEnable)
					t_nxt.st = ptl_pkg::stWaitRun;
			ptl_pkg::stWaitRun:
				if (runRise)
				begin
					t_nxt.reverse = returnModeSelect;
					t_nxt.moveTgt = returnModeSelect ? t_r.startPt : t_r.target;
					t_nxt.msCnt = '0;
					t_nxt.st = ptl_pkg::stStartDelay;
				end
			ptl_pkg::stStartDelay:
				if (t_r.msCnt >= t_r.startDelay)
					t_nxt.st = ptl_pkg::stRunning;
			ptl_pkg::stRunning:
				if (motorStopped)
				begin
					t_nxt.msCnt = '0;
					t_nxt.st = ptl_pkg::stEndWait;
				end
			ptl_pkg::stEndWait:
				if (t_r.msCnt >= endLimit)
				begin
					t_nxt.st = ptl_pkg::stResult;
					t_nxt.done = (absDev <= t_r.window);
					t_nxt.alarm = (absDev > t_r.window);
				end
			ptl_pkg::stResult:
			begin
				t_nxt.done = t_r.done;
				t_nxt.alarm = t_r.alarm;
			end
		endcase
		// run off aborts without a result
		if (t_r.st != ptl_pkg::stIdle && t_r.st != ptl_pkg::stWaitRun && !runCommand)
		begin
			t_nxt.st = ptl_pkg::stWaitRun;
			t_nxt.done = 1'b0;
			t_nxt.alarm = 1'b0;
		end
		if (!positionEnable)
		begin
			t_nxt.st = ptl_pkg::stIdle;
			t_nxt.done = 1'b0;
			t_nxt.alarm = 1'b0;
		end
		events[ptl_pkg::ST_DONE_BIT] = t_nxt.done & !t_r.done;
		events[ptl_pkg::ST_ALARM_BIT] = t_nxt.alarm & !t_r.alarm;
		// set wins over a write-one clear
		if (wrEn && wrAddr == ptl_pkg::REG_STATUS && wrStrb[0])
			t_nxt.status = t_r.status & ~wrData[ptl_pkg::ST_W-1:0];
		t_nxt.status = t_nxt.status | events;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			t_r <= '0;
			t_r.startDelay <= ptl_pkg::START_DELAY_RST;
			t_r.endWait <= ptl_pkg::END_WAIT_RST;
			t_r.window <= ptl_pkg::WINDOW_RST;
		end
		else
			t_r <= t_nxt;
	end

	// timer window covers delay to end wait
	assign timerActiveOut = (t_r.st == ptl_pkg::stStartDelay) || (t_r.st == ptl_pkg::stRunning) ||
		(t_r.st == ptl_pkg::stEndWait);
	assign driveRun = (t_r.st == ptl_pkg::stRunning) || (t_r.st == ptl_pkg::stEndWait);
	assign positionCountOverflow = t_r.ovf;
	assign moveReverse = t_r.reverse;
	assign moveTarget = t_r.moveTgt;
	assign irq = |(t_r.status & t_r.mask);
endmodule : ptl_terminal
`default_nettype wire

// *** ptl_encoder_model.sv ***
// encoder model: single count pulses on request plus an index level
`default_nettype none
module ptl_encoder_model (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic fwdReq,
	input  wire logic revReq,
	input  wire logic idxReq,
	output logic      encoderPulseInput,
	output logic      encoderReverse,
	output logic      encoderIndex
);
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			encoderPulseInput <= 1'h0;
			encoderReverse <= 1'h0;
			encoderIndex <= 1'h0;
		end
		else
		begin
			encoderPulseInput <= (fwdReq | revReq) & !encoderPulseInput;
			// direction kept past the pulse, so a late count still sees it
			if (fwdReq | revReq)
				encoderReverse <= revReq;
			encoderIndex <= idxReq;
		end
	end
endmodule : ptl_encoder_model
`default_nettype wire

// *** ptl_terminal_checker.sv ***
// port assertions for the positioning terminal logic
`default_nettype none
module ptl_terminal_checker (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic positionEnable,
	input wire logic runCommand,
	input wire logic stopOverrunAlarm,
	input wire logic timerActiveOut,
	input wire logic positionDone,
	input wire logic positionCountOverflow
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	AST_DONE_HOLD: assert property ($rose(positionDone) |=> positionDone [*8])
		else $error("done dropped early");
	AST_ALARM_HOLD: assert property ($rose(stopOverrunAlarm) |=> stopOverrunAlarm [*8])
		else $error("alarm dropped early");
	AST_DONE_AFTER_WAIT: assert property ($rose(positionDone) |-> !timerActiveOut && !stopOverrunAlarm)
		else $error("done during wait");
	AST_ALARM_AFTER_WAIT: assert property ($rose(stopOverrunAlarm) |-> !timerActiveOut && !positionDone)
		else $error("alarm during wait");
	AST_IDLE_NO_TIMER: assert property (!positionEnable |=> !timerActiveOut)
		else $error("timer while disabled");
	AST_CANCEL_TIMER: assert property ($fell(runCommand) |-> ##[1:3] !timerActiveOut)
		else $error("timer kept after cancel");
	AST_CANCEL_NO_RESULT: assert property ($fell(runCommand) && timerActiveOut |->
		(!$rose(positionDone) && !$rose(stopOverrunAlarm)) [*4]) else $error("result after cancel");
	AST_RUN_CLEARS_OVF: assert property ($rose(runCommand) && positionEnable |-> ##[1:3] !positionCountOverflow)
		else $error("overflow kept on run");
	cover property ($rose(positionDone));
	cover property ($rose(stopOverrunAlarm));
	cover property ($rose(positionCountOverflow));
endmodule : ptl_terminal_checker
`default_nettype wire

// *** ptl_terminal_bench.sv ***
// self-checking bench for the positioning terminal logic
`default_nettype none
module ptl_terminal_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset_n, positionEnable, limitSwitchArm, encoderIndex, encoderPulseInput, encoderReverse;
	logic serialPulse, serialCountMode, returnModeSelect, runCommand, motorStopped, fwdReq, revReq, idxReq;
	logic stopOverrunAlarm, timerActiveOut, positionDone, positionCountOverflow, driveRun, moveReverse, irq;
	logic [ptl_pkg::POS_W-1:0] moveTarget;
	logic [ptl_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int fails = 0, total_checks = 0, cyc = 0;
	ptl_terminal #(.TICK_CYCLES(10)) ptl_terminal_i (.ref_clk, .reset_n, .positionEnable, .limitSwitchArm, .encoderIndex,
		.encoderPulseInput, .encoderReverse, .serialPulse, .serialCountMode, .returnModeSelect, .runCommand,
		.motorStopped, .stopOverrunAlarm, .timerActiveOut, .positionDone, .positionCountOverflow, .driveRun,
		.moveReverse, .moveTarget, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	ptl_encoder_model ptl_encoder_model_i (.ref_clk, .reset_n, .fwdReq, .revReq, .idxReq, .encoderPulseInput,
		.encoderReverse, .encoderIndex);
	initial
	begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	// three runs of the end wait dominate; the ceiling leaves twice that
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fails = fails + 1;
			end_of_test();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wt(1);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			wt(1);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		resp = s_axi_bresp;
	endtask : wr
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		wt(1);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			wt(1);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		resp = s_axi_rresp;
		chk(n, e, s_axi_rdata);
	endtask : rdc
	task automatic sp(input int n);
		repeat (n)
		begin
			wt(1);
			serialPulse <= 1'h1;
			wt(2);
			serialPulse <= 1'h0;
			wt(2);
		end
	endtask : sp
	task automatic step(input logic r);
		wt(1);
		{fwdReq, revReq} <= {!r, r};
		wt(2);
		{fwdReq, revReq} <= 2'h0;
		wt(8);
	endtask : step
	task automatic idx;
		wt(1);
		idxReq <= 1'h1;
		wt(3);
		idxReq <= 1'h0;
		wt(6);
	endtask : idx
	task automatic run(input logic [31:0] t, input logic ok);
		int i;
		wr(ptl_pkg::REG_TARGET, t);
		runCommand <= 1'h1;
		wt(30);
		chk("timer", 1'h1, timerActiveOut);
		chk("drive", 1'h1, driveRun);
		motorStopped <= 1'h1;
		wt(4900);
		chk("early", 1'h0, positionDone | stopOverrunAlarm);
		for (i = 0; i < 300 && !(positionDone | stopOverrunAlarm); i++)
			wt(1);
		chk("done", ok, positionDone);
		chk("alarm", !ok, stopOverrunAlarm);
		chk("timer off", 1'h0, timerActiveOut);
		chk("drive off", 1'h0, driveRun);
		{runCommand, motorStopped} <= 2'h0;
		wt(950);
		chk("held", 1'h1, positionDone | stopOverrunAlarm);
		wt(200);
	endtask : run
	initial
	begin
		{positionEnable, limitSwitchArm, serialPulse, serialCountMode, returnModeSelect, runCommand} = 6'h0;
		{motorStopped, fwdReq, revReq, idxReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		reset_n = 1'h0;
		wt(8);
		reset_n <= 1'h1;
		rdc("end wait", ptl_pkg::REG_END_WAIT, 32'h1F4);
		rdc("unmapped", 8'h3C, 32'h0);
		chk("rresp", ptl_pkg::RESP_SLVERR, resp);
		wr(ptl_pkg::REG_POSITION, 32'h5);
		chk("bresp", ptl_pkg::RESP_SLVERR, resp);
		$display("register test done");
		wr(ptl_pkg::REG_TARGET, 32'h55);
		serialCountMode <= 1'h1;
		wt(4);
		rdc("clear", ptl_pkg::REG_TARGET, 32'h0);
		sp(3);
		rdc("shared on", ptl_pkg::REG_TARGET, 32'h3);
		serialCountMode <= 1'h0;
		sp(2);
		rdc("shared off", ptl_pkg::REG_TARGET, 32'h3);
		wr(ptl_pkg::REG_CTRL, 32'h1);
		sp(2);
		rdc("exclusive", ptl_pkg::REG_TARGET, 32'h5);
		serialCountMode <= 1'h1;
		wt(4);
		rdc("reclear", ptl_pkg::REG_TARGET, 32'h0);
		$display("serial test done");
		wr(ptl_pkg::REG_WINDOW, 32'h5);
		positionEnable <= 1'h1;
		run(32'h5, 1'h1);
		run(32'h6, 1'h0);
		wr(ptl_pkg::REG_START_POINT, 32'h123);
		returnModeSelect <= 1'h1;
		runCommand <= 1'h1;
		wt(30);
		chk("reverse", 1'h1, moveReverse);
		chk("goal", 32'h123, moveTarget);
		rdc("kept", ptl_pkg::REG_TARGET, 32'h6);
		motorStopped <= 1'h1;
		wt(2000);
		runCommand <= 1'h0;
		wt(4);
		chk("cancel", 1'h0, timerActiveOut);
		wt(3500);
		chk("aborted", 1'h0, positionDone | stopOverrunAlarm);
		motorStopped <= 1'h0;
		$display("run test done");
		wr(ptl_pkg::REG_PRESET, 32'h98967F);
		wr(ptl_pkg::REG_MASK, 32'h4);
		limitSwitchArm <= 1'h1;
		wt(4);
		rdc("arm only", ptl_pkg::REG_POSITION, 32'h0);
		idx();
		rdc("preset", ptl_pkg::REG_POSITION, 32'h98967F);
		step(1'h0);
		chk("ovf", 1'h1, positionCountOverflow);
		chk("irq", 1'h1, irq);
		wr(ptl_pkg::REG_STATUS, 32'h4);
		chk("irq clear", 1'h0, irq);
		step(1'h1);
		chk("in range", 1'h0, positionCountOverflow);
		step(1'h0);
		chk("ovf set", 1'h1, positionCountOverflow);
		runCommand <= 1'h1;
		wt(4);
		chk("run clear", 1'h0, positionCountOverflow);
		runCommand <= 1'h0;
		step(1'h1);
		step(1'h0);
		chk("ovf again", 1'h1, positionCountOverflow);
		limitSwitchArm <= 1'h0;
		wr(ptl_pkg::REG_PRESET, 32'h989681);
		limitSwitchArm <= 1'h1;
		idx();
		chk("preset clear", 1'h0, positionCountOverflow);
		positionEnable <= 1'h0;
		runCommand <= 1'h1;
		wt(40);
		chk("disabled", 1'h0, timerActiveOut);
		$display("overflow test done");
		end_of_test();
	end
endmodule : ptl_terminal_bench
bind ptl_terminal ptl_terminal_checker ptl_terminal_checker_i (.ref_clk, .reset_n, .positionEnable, .runCommand,
	.stopOverrunAlarm, .timerActiveOut, .positionDone, .positionCountOverflow);
`default_nettype wire
